//--- window_cfg_defines.vh
// Register offsets, field positions and reset values for the window and strap block
`ifndef WINDOW_CFG_DEFINES_VH
`define WINDOW_CFG_DEFINES_VH
`define OFS_PREFETCH_WIN 12'h920
`define OFS_HOST_SPACE 12'h922
`define OFS_CARD_SPACE 12'h923
`define OFS_WIN_PROG 12'h924
`define OFS_CHIP_MODE 12'h925
`define WIN_FIELD_MASK 8'hDF
`define RST_HOST_SPACE 8'hC0
`define RST_CARD_SPACE 8'hC0
`define RST_WIN_PROG 8'h00
`define RST_PREFETCH 8'h00
`define BIT_IRQ_MODE_LO 0
`define BIT_IRQ_MODE_HI 1
`define BIT_PWR_MODE 2
`define BIT_RST_CAUSE 3
`define BIT_HW_SUSP_EN 4
`define BIT_NEW_SMBUS 5
`define BIT_MM_ARM 7
`define CHIP_MODE_WMASK 8'hB7
`define CHIP_MODE_RMASK 8'hBF
`define IRQ_SIDEBAND 2'h0
`define IRQ_EXT_HW 2'h1
`define IRQ_SERIAL_WAY 2'h2
`define IRQ_HOST_BUS 2'h3
`endif

//--- window_type_and_strap_config.v
// Window type selection and chip strap/mode control register bank
`timescale 1ns/1ps
`include "window_cfg_defines.vh"

// What this block does
// - Prefetch window register is read-only
// - Host type bit: 0 memory, 1 I/O
// - Card type bit: 0 memory, 1 I/O commands
// - Type 1: programmable, extra-control timing/size
// - Decode interrupt signalling mode field
// - Interrupt mode loaded from two straps
// - Power-control mode loaded from latch strap
// - Strap bits 2:0 also software writable
// - Bits 2:0 kept on wake segment reset
// - Bit 3 reports last reset cause
// - Mode 0: three-wire serial power control
// - Mode 1: two-wire SMBus, 32 kHz reference
// - Bit 5 selects old or new SMBus
// - External mode: expander load/data outputs
// - Serial-way: bidirectional irq line, LEDs
// - Suspend enable with low request pin
// - Video port enabled only by arm bit
module window_type_and_strap_config (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  input wire i_seg_reset,
  input wire i_wake_enable,
  // Register access
  input wire i_wr,
  input wire i_rd,
  input wire [11:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  // Strap and mode pins
  input wire [1:0] i_high_irq_strap_pin,
  input wire [1:0] i_serial_in_strap_pin,
  input wire i_latch_strap_pin,
  input wire i_suspend_req_n,
  // Window decode per window
  output wire [6:0] o_win_host_io,
  output wire [6:0] o_win_card_io,
  output wire [6:0] o_win_use_extra_ctrl,
  // Interrupt mode decode
  output wire o_sideband_serial_irq_mode,
  output wire o_ext_hw_irq_mode,
  output wire o_serial_way_irq_mode,
  output wire o_host_bus_irq_mode,
  output wire o_expander_pins_en,
  output wire o_serial_irq_line_oe_allow,
  output wire o_activity_led_en,
  // Power control and suspend
  output wire o_power_three_wire,
  output wire o_power_smbus,
  output wire o_power_smbus_new,
  output wire o_strap_pin_b,
  output wire o_video_port_en
);

  // ------------------------------------------------------------
  // Strap synchronisers
  // ------------------------------------------------------------
  reg [4:0] strap_s1_q;
  reg [4:0] strap_s2_q;
  reg susp_s1_q;
  reg susp_s2_q;
  // Strap pins: hi-irq pair (open/pd/pu) then serial-in pair, then latch
  always @(posedge i_mclk) begin
    strap_s1_q <= {i_latch_strap_pin, i_serial_in_strap_pin, i_high_irq_strap_pin};
    strap_s2_q <= strap_s1_q;
    susp_s1_q <= i_suspend_req_n;
    susp_s2_q <= susp_s1_q;
  end

  // Strap pair encoding: 2'b00 pull-down, 2'b01 pull-up, 2'b10 open
  function [1:0] strap_irq_mode;
    input [1:0] hi_irq_pair;
    input [1:0] ser_in_pair;
    begin
      if (hi_irq_pair == 2'h2 && ser_in_pair == 2'h1)
        strap_irq_mode = `IRQ_HOST_BUS;
      else if (hi_irq_pair == 2'h0 && ser_in_pair == 2'h0)
        strap_irq_mode = `IRQ_SERIAL_WAY;
      else if (hi_irq_pair == 2'h0 && ser_in_pair == 2'h1)
        strap_irq_mode = `IRQ_SIDEBAND;
      else
        strap_irq_mode = `IRQ_EXT_HW;
    end
  endfunction

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Seven window bits with the reserved bit squeezed out
  function [6:0] win_field;
    input [7:0] value;
    begin
      win_field = {value[7:6], value[4:0]};
    end
  endfunction

  function reg_hit;
    input strobe;
    input [11:0] addr;
    input [11:0] offset;
    begin
      reg_hit = strobe && (addr == offset);
    end
  endfunction

  // Reset cause and bit 6 are never taken from the bus
  function [7:0] chip_mode_merge;
    input [7:0] old_value;
    input [7:0] new_value;
    begin
      chip_mode_merge = (old_value & ~`CHIP_MODE_WMASK) | (new_value & `CHIP_MODE_WMASK);
    end
  endfunction

  // Reserved bit 6 always reads as zero
  function [7:0] chip_mode_view;
    input [7:0] value;
    begin
      chip_mode_view = value & `CHIP_MODE_RMASK;
    end
  endfunction

  // ------------------------------------------------------------
  // Register access decode
  // ------------------------------------------------------------
  wire wr_host_space;
  wire wr_card_space;
  wire wr_win_prog;
  wire wr_chip_mode;
  // Prefetch and unmapped offsets match no write
  assign wr_host_space = reg_hit(i_wr, i_addr, `OFS_HOST_SPACE);
  assign wr_card_space = reg_hit(i_wr, i_addr, `OFS_CARD_SPACE);
  assign wr_win_prog = reg_hit(i_wr, i_addr, `OFS_WIN_PROG);
  assign wr_chip_mode = reg_hit(i_wr, i_addr, `OFS_CHIP_MODE);

  // ------------------------------------------------------------
  // Reset context
  // ------------------------------------------------------------
  reg strap_load_q;
  reg keep_ctx_q;
  reg power_up_seen_q;
  wire keep_ctx;
  assign keep_ctx = i_seg_reset & i_wake_enable;

  // Straps load once, on the first edge after reset
  always @(posedge i_mclk) begin
    if (i_rst) begin
      strap_load_q <= 1'b1;
      keep_ctx_q <= keep_ctx;
    end else begin
      strap_load_q <= 1'b0;
    end
  end

  // Held through a segment reset, so a long reset keeps the cause
  always @(posedge i_mclk) begin
    if (i_rst) begin
      if (!i_seg_reset) begin
        power_up_seen_q <= 1'b0;
      end
    end else begin
      power_up_seen_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Register next values
  // ------------------------------------------------------------
  reg [7:0] host_space_q;
  reg [7:0] card_space_q;
  reg [7:0] win_prog_q;
  reg [7:0] chip_mode_q;
  reg [7:0] host_space_d;
  reg [7:0] card_space_d;
  reg [7:0] win_prog_d;
  reg [7:0] chip_mode_d;

  always @* begin
    host_space_d = host_space_q;
    card_space_d = card_space_q;
    win_prog_d = win_prog_q;
    chip_mode_d = chip_mode_q;
    if (i_rst) begin
      host_space_d = `RST_HOST_SPACE;
      card_space_d = `RST_CARD_SPACE;
      win_prog_d = `RST_WIN_PROG;
      chip_mode_d[7:4] = 4'h0;
      if (!keep_ctx) begin
        chip_mode_d[3:0] = 4'h0;
      end
      if (i_seg_reset) begin
        chip_mode_d[`BIT_RST_CAUSE] = power_up_seen_q;
      end
    end else if (strap_load_q && !keep_ctx_q) begin
      chip_mode_d[1:0] = strap_irq_mode(strap_s2_q[1:0], strap_s2_q[3:2]);
      chip_mode_d[`BIT_PWR_MODE] = strap_s2_q[4];
    end else begin
      if (wr_host_space) begin
        host_space_d = i_wdata & `WIN_FIELD_MASK;
      end
      if (wr_card_space) begin
        card_space_d = i_wdata & `WIN_FIELD_MASK;
      end
      if (wr_win_prog) begin
        win_prog_d = i_wdata & `WIN_FIELD_MASK;
      end
      if (wr_chip_mode) begin
        chip_mode_d = chip_mode_merge(chip_mode_q, i_wdata);
      end
    end
  end

  always @(posedge i_mclk) begin
    host_space_q <= host_space_d;
    card_space_q <= card_space_d;
    win_prog_q <= win_prog_d;
    chip_mode_q <= chip_mode_d;
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  reg [7:0] rdata_d;

  // Read data holds until the next read
  always @* begin
    rdata_d = o_rdata;
    if (i_rst) begin
      rdata_d = 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `OFS_PREFETCH_WIN: rdata_d = `RST_PREFETCH;
        `OFS_HOST_SPACE: rdata_d = host_space_q;
        `OFS_CARD_SPACE: rdata_d = card_space_q;
        `OFS_WIN_PROG: rdata_d = win_prog_q;
        `OFS_CHIP_MODE: rdata_d = chip_mode_view(chip_mode_q);
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge i_mclk) begin
    o_rdata <= rdata_d;
  end

  // ------------------------------------------------------------
  // Window decode
  // ------------------------------------------------------------
  // Decoded from next values so outputs track the registers
  reg [6:0] win_host_io_q;
  reg [6:0] win_card_io_q;
  reg [6:0] win_extra_ctrl_q;
  wire [6:0] win_prog_bits_d;
  assign win_prog_bits_d = win_field(win_prog_d);

  always @(posedge i_mclk) begin
    win_host_io_q <= win_prog_bits_d & win_field(host_space_d);
    win_card_io_q <= win_prog_bits_d & win_field(card_space_d);
    win_extra_ctrl_q <= win_prog_bits_d;
  end

  assign o_win_host_io = win_host_io_q;
  assign o_win_card_io = win_card_io_q;
  assign o_win_use_extra_ctrl = win_extra_ctrl_q;

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  reg sideband_mode_q;
  reg ext_hw_mode_q;
  reg serial_way_mode_q;
  reg host_bus_mode_q;
  wire [1:0] irq_mode_d;
  assign irq_mode_d = chip_mode_d[1:0];

  always @(posedge i_mclk) begin
    sideband_mode_q <= (irq_mode_d == `IRQ_SIDEBAND);
    ext_hw_mode_q <= (irq_mode_d == `IRQ_EXT_HW);
    serial_way_mode_q <= (irq_mode_d == `IRQ_SERIAL_WAY);
    host_bus_mode_q <= (irq_mode_d == `IRQ_HOST_BUS);
  end

  assign o_sideband_serial_irq_mode = sideband_mode_q;
  assign o_ext_hw_irq_mode = ext_hw_mode_q;
  assign o_serial_way_irq_mode = serial_way_mode_q;
  assign o_host_bus_irq_mode = host_bus_mode_q;
  // Pin roles follow the interrupt signalling mode
  assign o_expander_pins_en = ext_hw_mode_q;
  assign o_serial_irq_line_oe_allow = serial_way_mode_q;
  assign o_activity_led_en = serial_way_mode_q;

  // ------------------------------------------------------------
  // Power control and suspend
  // ------------------------------------------------------------
  reg power_three_wire_q;
  reg power_smbus_q;
  reg power_smbus_new_q;
  reg strap_pin_b_q;
  reg video_port_en_q;

  // Suspend reads only the second synchroniser stage
  always @(posedge i_mclk) begin
    power_three_wire_q <= ~chip_mode_d[`BIT_PWR_MODE];
    power_smbus_q <= chip_mode_d[`BIT_PWR_MODE];
    power_smbus_new_q <= chip_mode_d[`BIT_PWR_MODE] & chip_mode_d[`BIT_NEW_SMBUS];
    strap_pin_b_q <= chip_mode_d[`BIT_HW_SUSP_EN] & ~susp_s2_q;
    video_port_en_q <= chip_mode_d[`BIT_MM_ARM];
  end

  assign o_power_three_wire = power_three_wire_q;
  assign o_power_smbus = power_smbus_q;
  assign o_power_smbus_new = power_smbus_new_q;
  assign o_strap_pin_b = strap_pin_b_q;
  assign o_video_port_en = video_port_en_q;

endmodule // window_type_and_strap_config

//--- window_cfg_sva.sv
// Checker for the window and strap register bank
`timescale 1ns/1ps
`include "window_cfg_defines.vh"
module window_cfg_sva (
  input wire logic i_mclk, i_rst, i_wr, i_rd, i_suspend_req_n,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata,
  input wire logic [6:0] o_win_host_io, o_win_card_io, o_win_use_extra_ctrl,
  input wire logic o_sideband_serial_irq_mode, o_ext_hw_irq_mode, o_serial_way_irq_mode,
  input wire logic o_host_bus_irq_mode, o_expander_pins_en, o_serial_irq_line_oe_allow,
  input wire logic o_activity_led_en, o_power_three_wire, o_power_smbus,
  input wire logic o_power_smbus_new, o_strap_pin_b
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  host_io_a: assert property ((o_win_host_io & ~o_win_use_extra_ctrl) == 7'h00)
    else $error("host io on default window");
  card_io_a: assert property ((o_win_card_io & ~o_win_use_extra_ctrl) == 7'h00)
    else $error("card io on default window");
  win_prog_a: assert property (i_wr && i_addr == `OFS_WIN_PROG |=>
    o_win_use_extra_ctrl == {$past(i_wdata[7:6]), $past(i_wdata[4:0])}) else $error("bad type");
  irq_hot_a: assert property ($onehot({o_sideband_serial_irq_mode, o_ext_hw_irq_mode,
    o_serial_way_irq_mode, o_host_bus_irq_mode})) else $error("irq mode not one-hot");
  pin_role_a: assert property ({o_expander_pins_en, o_serial_irq_line_oe_allow,
    o_activity_led_en} == {o_ext_hw_irq_mode, o_serial_way_irq_mode, o_serial_way_irq_mode})
    else $error("pin role mismatch");
  pwr_mode_a: assert property (o_power_three_wire != o_power_smbus &&
    (!o_power_smbus_new || o_power_smbus)) else $error("power mode mismatch");
  suspend_a: assert property (o_strap_pin_b |-> !$past(i_suspend_req_n, 3))
    else $error("suspend without request");
  prefetch_a: assert property (i_rd && i_addr == `OFS_PREFETCH_WIN |=> o_rdata == 8'h00)
    else $error("prefetch read not zero");
  cover property (o_strap_pin_b);
  cover property (o_power_smbus_new);
  cover property (o_serial_way_irq_mode);
endmodule // window_cfg_sva

//--- strap_board.sv
// Board strap resistor model for the mode pins
`timescale 1ns/1ps
module strap_board (
  input wire logic [1:0] i_mode,
  output logic [1:0] o_high_irq,
  output logic [1:0] o_serial_in
);
  // Codes: 00 pull-down, 01 pull-up, 10 open
  always_comb begin
    case (i_mode)
      2'h3: {o_high_irq, o_serial_in} = 4'h9;
      2'h2: {o_high_irq, o_serial_in} = 4'h0;
      2'h0: {o_high_irq, o_serial_in} = 4'h1;
      default: {o_high_irq, o_serial_in} = 4'h8;
    endcase
  end
endmodule // strap_board

//--- window_type_and_strap_config_tb.sv
// Self-checking bench for the window and strap register bank
`timescale 1ns/1ps
`include "window_cfg_defines.vh"
module window_type_and_strap_config_tb;
  logic i_mclk = 0, i_rst = 1, i_seg_reset = 0, i_wake_enable = 0, i_wr = 0, i_rd = 0;
  logic i_latch_strap_pin = 0, i_suspend_req_n = 1;
  logic [11:0] i_addr = 12'h000;
  logic [7:0] i_wdata = 8'h00, o_rdata, d, w;
  logic [1:0] mode = 2'h0, i_high_irq_strap_pin, i_serial_in_strap_pin;
  logic [6:0] o_win_host_io, o_win_card_io, o_win_use_extra_ctrl;
  logic o_sideband_serial_irq_mode, o_ext_hw_irq_mode, o_serial_way_irq_mode;
  logic o_host_bus_irq_mode, o_expander_pins_en, o_serial_irq_line_oe_allow;
  logic o_activity_led_en, o_power_three_wire, o_power_smbus, o_power_smbus_new;
  logic o_strap_pin_b, o_video_port_en;
  int num_errors = 0, check_count = 0, seed = 69437;
  logic [11:0] ra [5] = '{12'h920, 12'h922, 12'h923, 12'h924, 12'h926};
  logic [7:0] rv [5] = '{8'h00, 8'hC0, 8'hC0, 8'h00, 8'h00};
  logic [7:0] rm [5] = '{8'h00, 8'hDF, 8'hDF, 8'hDF, 8'h00};
  always #2.5 i_mclk = ~i_mclk;
  strap_board u_straps (.i_mode(mode), .o_high_irq(i_high_irq_strap_pin),
    .o_serial_in(i_serial_in_strap_pin));
  window_type_and_strap_config dut (.*);
  function automatic logic [7:0] win(input logic [7:0] v);
    return {1'b0, v[7:6], v[4:0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] v);
    @(negedge i_mclk);
    {i_wr, i_rd, i_addr, i_wdata} = {wr, !wr, a, v};
    @(negedge i_mclk);
    {i_wr, i_rd} = 2'b00;
    @(negedge i_mclk);
  endtask
  task automatic reset(input logic seg, input logic wake);
    {i_rst, i_seg_reset, i_wake_enable} = {1'b1, seg, wake};
    repeat (4) @(negedge i_mclk);
    i_rst = 0;
    repeat (2) @(negedge i_mclk);
  endtask
  task automatic summarize;
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      i_latch_strap_pin = $random(seed);
      reset(0, 0);
      bus(0, `OFS_CHIP_MODE, 8'h00);
      check(o_rdata, {5'h00, i_latch_strap_pin, mode});
      check({o_host_bus_irq_mode, o_serial_way_irq_mode, o_ext_hw_irq_mode,
        o_sideband_serial_irq_mode}, 8'h01 << m);
      check({o_expander_pins_en, o_serial_irq_line_oe_allow, o_activity_led_en, o_power_smbus},
        {m == 1, m == 2, m == 2, i_latch_strap_pin});
    end
    for (int i = 0; i < 5; i++) begin
      bus(0, ra[i], 8'h00);
      check(o_rdata, rv[i]);
      bus(1, ra[i], 8'hFF);
      bus(0, ra[i], 8'h00);
      check(o_rdata, rm[i]);
    end
    repeat (20) begin
      d = $random(seed);
      w = $random(seed);
      bus(1, `OFS_HOST_SPACE, d);
      bus(1, `OFS_CARD_SPACE, ~d);
      bus(1, `OFS_WIN_PROG, w);
      check(o_win_host_io, win(d & w));
      check(o_win_card_io, win(~d & w));
      check(o_win_use_extra_ctrl, win(w));
    end
    repeat (10) begin
      d = $random(seed);
      bus(1, `OFS_CHIP_MODE, d);
      bus(0, `OFS_CHIP_MODE, 8'h00);
      check(o_rdata, d & `CHIP_MODE_WMASK);
      check({o_video_port_en, o_power_smbus_new, o_power_three_wire},
        {d[7], d[2] & d[5], !d[2]});
    end
    bus(1, `OFS_CHIP_MODE, 8'h13);
    i_suspend_req_n = 0;
    repeat (3) @(negedge i_mclk);
    check(o_strap_pin_b, 8'h01);
    mode = 2'h0;
    i_latch_strap_pin = 0;
    reset(1, 1);
    bus(0, `OFS_CHIP_MODE, 8'h00);
    check(o_rdata, 8'h0B);
    check(o_strap_pin_b, 8'h00);
    reset(1, 0);
    bus(0, `OFS_CHIP_MODE, 8'h00);
    check(o_rdata, 8'h08);
    summarize();
  end
endmodule // window_type_and_strap_config_tb
bind window_type_and_strap_config window_cfg_sva u_sva (.*);
